//--- logic/ast_baud.sv
// baud generator: one sub-tick every divisor plus one clock cycles
`timescale 1ns/1ps
module ast_baud import ast_pkg::*; (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // control
   input  wire logic       run,
   input  wire logic [7:0] divisor,
   // tick
   output logic            tick
);

   logic [7:0] cnt_q;

   // ==========================================================
   // down counter; reloads from the divisor at zero or while stopped, so a new value takes hold at the next reload
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
      end else if (!run || cnt_q == 8'h00) begin
         cnt_q <= divisor;
      end else begin
         cnt_q <= cnt_q - 8'h01;
      end
   end

   assign tick = run & (cnt_q == 8'h00);

   tick_gap_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      tick && divisor == 8'h01 && $stable(divisor) |=> !tick)
      else $error("baud tick repeated too soon");

endmodule

//--- logic/ast_pkg.sv
// constants and types shared by the asynchronous serial transmitter
// What this block does
// - frames are NRZ: one start bit, eight or nine data bits, one stop bit
// - data bits leave least significant bit first
// - baud generator runs at x16 or x64 the bit rate, chosen by control bit 2
// - with high speed set, bit rate is oscillator over sixteen times divisor plus one
// - no hardware parity; software carries any parity as the ninth bit
// - all asynchronous activity halts while the device sleeps
// - asynchronous operation is selected while control bit 4 is clear
// - shift register reloads only after the stop bit, at once if data waits
// - the buffer-to-shifter move takes one cycle and then sets the buffer-empty flag
// - interrupt request only when buffer-empty flag and its enable are both set
// - read-only shifter-empty status at bit 1, set while shifter empty, no interrupt
// - the shift register has no software address
// - setting transmit enable also sets the buffer-empty flag
// - enable is bit 5; a frame starts only with buffered data and a shift clock
// - loading the buffer first and enabling afterwards also starts transmission
// - a write to an empty shifter passes through, freeing the buffer for another byte
// - clearing transmit enable mid-frame aborts, resets and floats the serial output
// - control bit 6 selects nine-bit frames, ninth value taken from control bit 0
// - transmitter and receiver share one frame format and one baud setting
package ast_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] AST_CTRL_OFS = 8'h00;
   localparam logic [7:0] AST_HOLD_OFS = 8'h04;
   localparam logic [7:0] AST_DIV_OFS  = 8'h08;
   localparam logic [7:0] AST_STAT_OFS = 8'h0C;

   // ==========================================================
   // field positions
   localparam int AST_CTRL_NINTH_VAL = 0;
   localparam int AST_CTRL_SH_EMPTY  = 1;
   localparam int AST_CTRL_HS        = 2;
   localparam int AST_CTRL_CLK_MODE  = 4;
   localparam int AST_CTRL_TX_EN     = 5;
   localparam int AST_CTRL_NINE      = 6;
   localparam int AST_STAT_FLAG      = 0;
   localparam int AST_STAT_IE        = 1;
   localparam int AST_STAT_PORT_EN   = 2;

   // ==========================================================
   // reset values and control write mask
   localparam logic [7:0] AST_CTRL_RST = 8'h00;
   localparam logic [7:0] AST_HOLD_RST = 8'h00;
   localparam logic [7:0] AST_DIV_RST  = 8'h00;
   localparam logic [7:0] AST_CTRL_WMASK = 8'hF5;

   // ==========================================================
   // baud sub-ticks per bit, minus one
   localparam logic [5:0] AST_SUB_HS = 6'h0F;
   localparam logic [5:0] AST_SUB_LS = 6'h3F;

   typedef enum logic [2:0] {
      AST_IDLE  = 3'h0,
      AST_LOAD  = 3'h1,
      AST_START = 3'h3,
      AST_DATA  = 3'h2,
      AST_STOP  = 3'h6
   } ast_state_t;

   function automatic logic [5:0] ast_sub_limit(input logic hs);
      ast_sub_limit = hs ? AST_SUB_HS : AST_SUB_LS;
   endfunction

endpackage

//--- logic/ast_shift.sv
// transmit shift register with frame sequencing
`timescale 1ns/1ps
module ast_shift import ast_pkg::*; (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // control
   input  wire logic       clear,
   input  wire logic       hold,
   input  wire logic       sub_tick,
   input  wire logic       hs,
   input  wire logic       nine,
   // load
   input  wire logic       load,
   input  wire logic [8:0] load_data,
   // status and line
   output logic            busy,
   output logic            txd
);

   ast_state_t state_q;
   logic [8:0] sr_q;
   logic [5:0] sub_q;
   logic [3:0] cnt_q;
   logic       txd_q;

   wire bit_end = sub_tick & (sub_q == ast_sub_limit(hs));
   wire timing  = (state_q != AST_IDLE) & (state_q != AST_LOAD);

   // ==========================================================
   // frame sequencer; clear aborts, hold freezes everything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= AST_IDLE;
         sr_q    <= 9'h000;
         cnt_q   <= 4'h0;
         txd_q   <= 1'b1;
      end else if (clear) begin
         state_q <= AST_IDLE;
         txd_q   <= 1'b1;
      end else if (!hold) begin
         case (state_q)
            AST_IDLE: begin
               if (load) begin
                  sr_q    <= load_data;
                  cnt_q   <= nine ? 4'h8 : 4'h7;
                  state_q <= AST_LOAD;
               end
            end
            AST_LOAD: begin
               if (sub_tick) begin
                  state_q <= AST_START;
                  txd_q   <= 1'b0;
               end
            end
            AST_START: begin
               if (bit_end) begin
                  state_q <= AST_DATA;
                  txd_q   <= sr_q[0];
                  sr_q    <= {1'b0, sr_q[8:1]};
               end
            end
            AST_DATA: begin
               if (bit_end && cnt_q == 4'h0) begin
                  state_q <= AST_STOP;
                  txd_q   <= 1'b1;
               end else if (bit_end) begin
                  txd_q <= sr_q[0];
                  sr_q  <= {1'b0, sr_q[8:1]};
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            AST_STOP: begin
               if (bit_end) begin
                  state_q <= AST_IDLE;
               end
            end
            default: begin
               state_q <= AST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // sub-tick counter restarts with each start bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_q <= 6'h00;
      end else if (clear || hold) begin
         sub_q <= clear ? 6'h00 : sub_q;
      end else if (state_q == AST_LOAD) begin
         sub_q <= 6'h00;
      end else if (timing && sub_tick) begin
         sub_q <= bit_end ? 6'h00 : sub_q + 6'h01;
      end
   end

   assign busy = (state_q != AST_IDLE);
   assign txd  = txd_q;

   stop_high_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      state_q == AST_STOP |-> txd_q)
      else $error("stop bit not high");

endmodule

//--- logic/ast_tx.sv
// asynchronous serial transmitter with apb register slave
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module ast_tx import ast_pkg::*; (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // core
   input  wire logic        sleep,
   output logic             irq,
   // shared with the receiver
   output logic             baud_tick,
   output logic             frame_nine,
   output logic             frame_hs,
   // serial pin
   output logic             serial_out,
   output logic             serial_out_oe
);

   // ==========================================================
   // state
   logic [7:0]  ctrl_q;
   logic [7:0]  hold_q;
   logic [7:0]  div_q;
   logic        hold_full_q;
   logic        flag_q;
   logic        flag_d;
   logic        irq_en_q;
   logic        port_en_q;
   logic        tx_en_d1_q;
   logic        run_q;
   logic [31:0] prdata_q;
   logic        busy;
   logic        txd;

   // ==========================================================
   // apb decode
   wire setup    = psel & ~penable;
   wire access   = psel & penable;
   wire sel_ctrl = (paddr == AST_CTRL_OFS);
   wire sel_hold = (paddr == AST_HOLD_OFS);
   wire sel_div  = (paddr == AST_DIV_OFS);
   wire sel_stat = (paddr == AST_STAT_OFS);
   // no decode exists for the shift register itself
   wire mapped   = sel_ctrl | sel_hold | sel_div | sel_stat;
   wire wr       = access & pwrite & mapped;
   wire wr_ctrl  = wr & sel_ctrl;
   wire wr_hold  = wr & sel_hold;
   wire wr_div   = wr & sel_div;
   wire wr_stat  = wr & sel_stat;

   // ==========================================================
   // transmit control
   wire tx_en    = ctrl_q[AST_CTRL_TX_EN];
   wire async_md = ~ctrl_q[AST_CTRL_CLK_MODE];
   wire run      = port_en_q & tx_en & async_md;
   wire en_rise  = tx_en & ~tx_en_d1_q;
   // a load waits one cycle behind a buffer write so set and clear never meet
   wire load     = run & ~sleep & hold_full_q & ~busy & ~wr_hold;
   // ninth bit is whatever software placed there, parity included
   wire [8:0] load_data = {ctrl_q[AST_CTRL_NINTH_VAL], hold_q};

   // ==========================================================
   // read mux
   wire [7:0] ctrl_rd = {ctrl_q[7:2], ~busy, ctrl_q[0]};
   wire [7:0] stat_rd = {5'h00, port_en_q, irq_en_q, flag_q};
   wire [7:0] rd_mux  = sel_ctrl ? ctrl_rd :
                        sel_hold ? hold_q :
                        sel_div  ? div_q :
                        sel_stat ? stat_rd : 8'h00;

   // ==========================================================
   // register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= AST_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= pwdata[7:0] & AST_CTRL_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= AST_DIV_RST;
      end else if (wr_div) begin
         div_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_q  <= 1'b0;
         port_en_q <= 1'b0;
      end else if (wr_stat) begin
         irq_en_q  <= pwdata[AST_STAT_IE];
         port_en_q <= pwdata[AST_STAT_PORT_EN];
      end
   end

   // ==========================================================
   // holding buffer; its contents survive a disable so load-then-enable works
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q      <= AST_HOLD_RST;
         hold_full_q <= 1'b0;
      end else if (wr_hold) begin
         hold_q      <= pwdata[7:0];
         hold_full_q <= 1'b1;
      end else if (load) begin
         hold_full_q <= 1'b0;
      end
   end

   // ==========================================================
   // buffer-empty flag; setting wins over a clearing write
   always_comb begin
      flag_d = flag_q;
      if (wr_hold) begin
         flag_d = 1'b0;
      end
      if (load || en_rise) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q     <= 1'b1;
         tx_en_d1_q <= 1'b0;
         run_q      <= 1'b0;
      end else begin
         flag_q     <= flag_d;
         tx_en_d1_q <= tx_en;
         run_q      <= run;
      end
   end

   // ==========================================================
   // read data is captured in the setup cycle, so no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup) begin
         prdata_q <= {24'h00_0000, rd_mux};
      end
   end

   // ==========================================================
   // datapath
   ast_baud u_baud (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (run & ~sleep),
      .divisor (div_q),
      .tick    (baud_tick)
   );

   ast_shift u_shift (
      .pclk      (pclk),
      .presetn   (presetn),
      .clear     (~run),
      .hold      (sleep),
      .sub_tick  (baud_tick),
      .hs        (ctrl_q[AST_CTRL_HS]),
      .nine      (ctrl_q[AST_CTRL_NINE]),
      .load      (load),
      .load_data (load_data),
      .busy      (busy),
      .txd       (txd)
   );

   // ==========================================================
   // outputs
   assign prdata        = prdata_q;
   assign pready        = 1'b1;
   assign pslverr       = access & ~mapped;
   assign irq           = flag_q & irq_en_q;
   assign frame_nine    = ctrl_q[AST_CTRL_NINE];
   assign frame_hs      = ctrl_q[AST_CTRL_HS];
   assign serial_out    = txd;
   assign serial_out_oe = run_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence load_seq;
      run && !sleep && hold_full_q && !busy && !wr_hold;
   endsequence

   sequence loaded_seq;
      busy && !hold_full_q && flag_q;
   endsequence

   load_pass_a:
   assert property (load_seq |=> loaded_seq)
      else $error("buffer not moved into empty shifter");

   flag_after_a:
   assert property (load |=> flag_q && !hold_full_q)
      else $error("flag not set after transfer");

   irq_gate_a:
   assert property (irq |-> flag_q && irq_en_q)
      else $error("interrupt without flag and enable");

   enable_flag_a:
   assert property ($rose(tx_en) |=> flag_q)
      else $error("enable did not set flag");

   write_clear_a:
   assert property (wr_hold && !en_rise |=> !flag_q && hold_full_q)
      else $error("buffer write left flag set");

   abort_float_a:
   assert property ($fell(run) |=> !serial_out_oe && !busy && serial_out)
      else $error("disable did not abort the frame");

   sleep_freeze_a:
   assert property (sleep && busy && run |=> $stable(serial_out) && busy)
      else $error("line moved during sleep");

   idle_high_a:
   assert property (!busy |-> serial_out)
      else $error("idle line not high");

   no_early_load_a:
   assert property (busy && hold_full_q |=> hold_full_q || !busy)
      else $error("reload before stop bit ended");

   empty_status_a:
   assert property (setup && sel_ctrl |=> prdata[AST_CTRL_SH_EMPTY] == !$past(busy))
      else $error("shifter empty status wrong");

endmodule

//--- sim/ast_rx_model.sv
// behavioural remote receiver watching the serial line
`timescale 1ns/1ps
module ast_rx_model (
   // clock
   input  wire logic        pclk,
   // line
   input  wire logic        line,
   input  wire logic        line_oe,
   // frame format
   input  wire logic        nine,
   input  wire logic [15:0] bit_cyc,
   // result
   output logic             frame_vld,
   output logic [8:0]       frame_q
);
   int   i;
   logic ok;
   // ==========================================================
   // frame decoder
   // sampled at mid bit; a released line discards the frame
   initial begin
      frame_vld = 1'b0;
      frame_q   = 9'h000;
      forever begin
         @(posedge pclk);
         frame_vld <= 1'b0;
         if (line === 1'b0 && line_oe === 1'b1) begin
            ok      = 1'b1;
            frame_q = 9'h000;
            repeat (bit_cyc / 2) @(posedge pclk);
            ok = ok & (line === 1'b0);
            for (i = 0; i < (nine ? 10 : 9); i++) begin
               repeat (bit_cyc) @(posedge pclk);
               ok = ok & (line_oe === 1'b1);
               if (i < (nine ? 9 : 8)) frame_q[i] = line;
               else ok = ok & (line === 1'b1);
            end
            if (ok) frame_vld <= 1'b1;
         end
      end
   end
endmodule

//--- sim/test_async_serial_transmitter.sv
// self-checking bench for the asynchronous serial transmitter
`timescale 1ns/1ps
module test_async_serial_transmitter import ast_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, sleep, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, seed, v;
   logic        pready, pslverr, irq, baud_tick, frame_nine, frame_hs;
   logic        serial_out, serial_out_oe, line, nine, frame_vld;
   logic [15:0] bit_cyc;
   logic [8:0]  frame_q;
   logic [8:0]  exp_q[$];
   int          err_total, n_tests, k;
   // line has a pull-up, so a released pin reads high
   assign line = serial_out_oe ? serial_out : 1'b1;
   always #2.5 pclk = ~pclk;
   ast_tx u_ast_tx (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep(sleep), .irq(irq), .baud_tick(baud_tick),
      .frame_nine(frame_nine), .frame_hs(frame_hs), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe));
   ast_rx_model u_ast_rx_model (.pclk(pclk), .line(line), .line_oe(serial_out_oe),
      .nine(nine), .bit_cyc(bit_cyc), .frame_vld(frame_vld), .frame_q(frame_q));
   // ==========================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // master holds the request until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
      if (n >= 50) begin
         err_total++;
         print_verdict();
      end
   endtask
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask
   task automatic cfg(input logic [7:0] div, input logic [7:0] ctrl);
      bit_cyc <= 16'((ctrl[AST_CTRL_HS] ? 16 : 64) * (int'(div) + 1));
      nine    <= ctrl[AST_CTRL_NINE];
      apb(1'b1, AST_DIV_OFS, {24'h0, div});
      apb(1'b1, AST_CTRL_OFS, {24'h0, ctrl});
   endtask
   task automatic send(input logic [8:0] f);
      exp_q.push_back(f);
      apb(1'b1, AST_HOLD_OFS, {24'h0, f[7:0]});
   endtask
   task automatic wait_idle(input string name);
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 40000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 40000) begin
         err_total++;
         print_verdict();
      end
      repeat (bit_cyc) @(posedge pclk);
      $display("test %s done", name);
   endtask
   // ==========================================================
   // frame watcher
   always @(posedge pclk) begin
      if (frame_vld === 1'b1) begin
         if (exp_q.size() == 0) chk({23'h0, frame_q}, 32'hFFFFFFFF);
         else chk({23'h0, frame_q}, {23'h0, exp_q.pop_front()});
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
      pwdata = 32'h0; sleep = 0; nine = 0; bit_cyc = 16'h0010; seed = 32'h5CF9;
      err_total = 0; n_tests = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, AST_CTRL_OFS, 32'h0); chk(rd, 32'h00000002);
      apb(1'b0, AST_STAT_OFS, 32'h0); chk(rd, 32'h00000001);
      apb(1'b0, 8'h10, 32'h0); chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      chk({31'h0, serial_out_oe}, 32'h0);
      // setup in the documented order
      cfg(8'h00, 8'h04);
      apb(1'b1, AST_STAT_OFS, 32'h00000006);
      cfg(8'h00, 8'h24);
      settle(); chk({31'h0, irq}, 32'h1);
      v = rnd(); send({1'b0, v[7:0]});
      v = rnd(); send({1'b0, v[7:0]});
      settle(); chk({31'h0, irq}, 32'h0);
      apb(1'b0, AST_STAT_OFS, 32'h0); chk(rd, 32'h00000006);
      wait_idle("back_to_back");
      apb(1'b0, AST_STAT_OFS, 32'h0); chk(rd, 32'h00000007);
      apb(1'b0, AST_CTRL_OFS, 32'h0); chk(rd, 32'h00000026);
      for (k = 0; k < 4; k++) begin
         v = rnd();
         cfg(8'(k % 3), {1'b0, k[0], 1'b1, 2'b00, k < 3, 1'b0, v[8]});
         chk({31'h0, frame_nine}, {31'h0, k[0]});
         send({v[8] & k[0], v[7:0]});
         wait_idle("format");
      end
      // sleep holds the frame back
      cfg(8'h00, 8'h24);
      @(posedge pclk);
      sleep <= 1'b1;
      v = rnd(); send({1'b0, v[7:0]});
      repeat (100) @(posedge pclk);
      #1; chk({31'h0, serial_out}, 32'h1);
      @(posedge pclk);
      sleep <= 1'b0;
      wait_idle("sleep");
      // sleep in the stop bit, after the partner has taken the frame
      v = rnd(); send({1'b0, v[7:0]});
      k = 0;
      while (exp_q.size() != 0 && k < 4000) begin
         @(posedge pclk);
         k++;
      end
      sleep <= 1'b1;
      repeat (50) @(posedge pclk);
      #1; chk({31'h0, serial_out}, 32'h1);
      chk({31'h0, serial_out_oe}, 32'h1);
      @(posedge pclk);
      sleep <= 1'b0;
      wait_idle("sleep_stop");
      // abort mid frame; partner drops the partial frame
      apb(1'b1, AST_HOLD_OFS, 32'h000000A5);
      repeat (40) @(posedge pclk);
      apb(1'b1, AST_CTRL_OFS, 32'h00000004);
      settle(); chk({31'h0, serial_out_oe}, 32'h0);
      apb(1'b0, AST_CTRL_OFS, 32'h0); chk(rd, 32'h00000006);
      // the partner is still walking the cut frame; let it finish first
      repeat (10 * bit_cyc) @(posedge pclk);
      // load first, enable afterwards
      v = rnd(); send({1'b0, v[7:0]});
      apb(1'b1, AST_CTRL_OFS, 32'h00000024);
      wait_idle("load_first");
      apb(1'b1, AST_CTRL_OFS, 32'h00000034);
      settle(); chk({31'h0, serial_out_oe}, 32'h0);
      print_verdict();
   end
endmodule
